// *** pkg/mms_pkg.sv ***
// package: register map, field positions, reset values and timing constants for mms block
`default_nettype none
package mms_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  // timing figures in their own units
  localparam int unsigned T_INIT_MS = 2000;
  localparam int unsigned T_RESET_MIN_US = 2;
  localparam int unsigned T_LP_ON_US = 100;
  localparam int unsigned T_LP_OFF_MS = 300;
  localparam int unsigned T_INT_ON_MS = 200;
  localparam int unsigned T_INT_OFF_US = 500;
  localparam int unsigned T_LOS_MS = 100;
  localparam int unsigned T_MASK_MS = 100;
  localparam int unsigned T_RATE_US = 100;
  localparam int unsigned T_PDOWN_ON_MS = 100;
  localparam int unsigned T_PDOWN_OFF_MS = 300;
  // cycle counts; least times round up, longest round down
  localparam int unsigned CYC_PER_US = CLK_HZ / 1000000;
  localparam int unsigned RESET_MIN_CYC = (T_RESET_MIN_US * CLK_HZ + 999999) / 1000000;
  localparam int unsigned LP_ON_CYC = T_LP_ON_US * CYC_PER_US;
  localparam int unsigned RATE_CYC = T_RATE_US * CYC_PER_US;
  localparam int unsigned INIT_CYC_DEF = T_INIT_MS * (CLK_HZ / 1000);
  localparam int unsigned LP_OFF_CYC_DEF = T_LP_OFF_MS * (CLK_HZ / 1000);
  // register offsets (byte addresses in the lower page)
  localparam logic [7:0] ADDR_ID = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h02;
  localparam logic [7:0] ADDR_FLAGS = 8'h03;
  localparam logic [7:0] ADDR_CONTROL = 8'h56;
  localparam logic [7:0] ADDR_MASK = 8'h64;
  localparam logic [7:0] ADDR_STATE = 8'h65;
  // field positions
  localparam int unsigned BIT_NOT_READY = 0;
  localparam int unsigned BIT_PDOWN = 0;
  localparam int unsigned BIT_RATE = 1;
  localparam int unsigned FLAG_LOS = 0;
  localparam int unsigned FLAG_TXF = 1;
  localparam int unsigned FLAG_OTHER = 2;
  localparam int unsigned NFLAG = 3;
  // reset values
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [NFLAG-1:0] RST_MASK = 3'h0;
  localparam logic [7:0] ID_VALUE = 8'h5A; // arbitrary identifier value
  typedef enum logic [1:0] {MMS_BOOT, MMS_READY, MMS_LOWPWR, MMS_WAKE} mms_state_e;
endpackage
`default_nettype wire

// *** verification/mms_core_assertions.sv ***
// checker: timing relations at the mms_core ports
`default_nettype none
module mms_core_assertions
  import mms_pkg::*;
#(
  parameter int unsigned INIT_CYC = 100,
  parameter int unsigned LP_OFF_CYC = 50
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic module_reset_n,
  input wire logic low_power_select,
  input wire logic rx_loss,
  input wire logic tx_fault,
  input wire logic other_alarm,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic bus_ready,
  input wire logic module_interrupt_n,
  input wire logic low_power,
  input wire logic rate_settled,
  input wire logic rate_high,
  input wire logic fully_functional
);
  // ----------
  // properties
  // ----------
  localparam int INIT_MAX = INIT_CYC + 10;
  localparam int RATE_LIM = RATE_CYC + 2;
  logic [2:0] cond;
  logic [2:0] mask_q;
  logic [5:0] lowcnt;
  logic [11:0] rcnt;
  assign cond = {other_alarm, tx_fault, rx_loss};
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // counters saturate so long holds never wrap
  always_ff @(posedge clk) begin
    if (reset) begin
      mask_q <= 3'h0;
      lowcnt <= 6'h00;
      rcnt <= 12'hFFF;
    end else begin
      if (wr && bus_ready && addr == ADDR_MASK) mask_q <= wdata[2:0];
      lowcnt <= module_reset_n ? 6'h00 : lowcnt + {5'h00, lowcnt != 6'h3F};
      rcnt <= ($changed(rate_high) || (wr && bus_ready && addr == ADDR_CONTROL)) ? 12'h000 :
              rcnt + {11'h000, rcnt != 12'hFFF};
    end
  end
  sequence s_ctl_wr; wr && bus_ready && addr == ADDR_CONTROL; endsequence
  sequence s_quiet; (cond == 3'h0)[*5]; endsequence
  property p_init; $fell(reset) && !low_power_select |-> ##[1:INIT_MAX] fully_functional; endproperty
  property p_ready_int; $rose(bus_ready) |-> ##[0:2] !module_interrupt_n; endproperty
  property p_pin_rst; lowcnt == 6'h2C |-> ##[0:4] !fully_functional; endproperty
  property p_pin_rel; $rose(module_reset_n) && lowcnt > 6'h2C |-> ##[1:INIT_MAX] fully_functional;
  endproperty
  property p_pdown; s_ctl_wr ##0 wdata[BIT_PDOWN] |-> ##[1:3] low_power; endproperty
  property p_flag_int; (|(cond & ~mask_q))[*4] ##0 bus_ready |-> ##[0:3] !module_interrupt_n;
  endproperty
  property p_read_clr; s_quiet ##0 rd && bus_ready && addr == ADDR_FLAGS |-> ##[1:4] module_interrupt_n;
  endproperty
  property p_rate; int'(rcnt) >= RATE_LIM |-> rate_settled; endproperty
  a_init: assert property (p_init) else $error("init late");
  a_ready_int: assert property (p_ready_int) else $error("no ready interrupt");
  a_pin_rst: assert property (p_pin_rst) else $error("pin reset ignored");
  a_pin_rel: assert property (p_pin_rel) else $error("restart late");
  a_pdown: assert property (p_pdown) else $error("power down late");
  a_flag_int: assert property (p_flag_int) else $error("interrupt missing");
  a_read_clr: assert property (p_read_clr) else $error("interrupt stuck");
  a_rate: assert property (p_rate) else $error("rate unsettled");
endmodule // mms_core_assertions
`default_nettype wire

// *** verification/mms_host_pins.sv ***
// partner: host-side reset and low-power pin driver
`default_nettype none
module mms_host_pins (
  input wire logic host_clk,
  input wire logic [3:0] pulse_len,
  input wire logic pulse_go,
  input wire logic lp_req,
  output logic module_reset_n,
  output logic low_power_select
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] left = 4'h0;
  logic lp_q = 1'b0;
  // whole host periods; a short pulse is a deliberate glitch
  assign module_reset_n = (left == 4'h0);
  assign low_power_select = lp_q;
  always @(posedge host_clk) begin
    lp_q <= lp_req;
    if (pulse_go && left == 4'h0) left <= pulse_len;
    else if (left != 4'h0) left <= left - 4'h1;
  end
endmodule // mms_host_pins
`default_nettype wire

// *** verification/module_mgmt_status_timing_tb_top.sv ***
// testbench: drives and checks the management status block
`default_nettype none
module module_mgmt_status_timing_tb_top
  import mms_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int INIT = 100;
  localparam int LPOFF = 50;
  logic clk = 1'b0, host_clk = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
  logic go = 1'b0, lp_req = 1'b0, rst_n, lps, bus_ready, irq_n, lp, rate, settled, fully;
  logic [2:0] cond = 3'h0;
  logic [3:0] plen = 4'h0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [7:0] exp_q[$];
  int failures = 0, comparisons = 0, cyc = 0, seed = 32'h8006, r;
  initial forever #25 clk = ~clk;
  initial begin
    #17;
    forever #200 host_clk = ~host_clk;
  end
  mms_core #(.INIT_CYC(INIT), .LP_OFF_CYC(LPOFF)) u_mms_core (
    .clk(clk), .reset(reset), .module_reset_n(rst_n), .low_power_select(lps),
    .rx_loss(cond[0]), .tx_fault(cond[1]), .other_alarm(cond[2]), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .bus_ready(bus_ready),
    .module_interrupt_n(irq_n), .low_power(lp), .rate_high(rate), .rate_settled(settled),
    .fully_functional(fully));
  mms_host_pins u_mms_host_pins (.host_clk(host_clk), .pulse_len(plen), .pulse_go(go),
    .lp_req(lp_req), .module_reset_n(rst_n), .low_power_select(lps));
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    comparisons++;
    if (seen !== want) begin
      failures++;
      $display("CHECK FAILED %0t got %h want %h", $time, seen, want);
    end
  endtask
  task automatic report_and_stop();
    if (failures == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    w(1);
    wr <= 1'b0;
    w(1);
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    addr <= a;
    rd <= 1'b1;
    w(1);
    rd <= 1'b0;
    w(1);
  endtask
  task automatic wait_ff(input int lim);
    for (int k = 0; k < lim && fully !== 1'b1; k++) w(1);
  endtask
  task automatic pin_pulse(input logic [3:0] n);
    plen <= n;
    go <= 1'b1;
    w(8);
    go <= 1'b0;
  endtask
  always @(posedge clk) begin
    rd_d <= rd;
    cyc <= cyc + 1;
    if (rd_d) check(rdata, exp_q.pop_front());
    if (cyc == 20000) begin
      failures++;
      report_and_stop();
    end
  end
  initial begin
    w(5);
    reset <= 1'b0;
    rd_reg(ADDR_ID, 8'h00);
    wait_ff(INIT + 20);
    w(2);
    check({6'h00, fully, irq_n}, 8'h02);
    rd_reg(ADDR_ID, ID_VALUE);
    rd_reg(ADDR_STATUS, 8'h00);
    rd_reg(ADDR_STATE, {4'h0, 1'b0, 1'b1, 2'(MMS_READY)});
    w(3);
    check({7'h00, irq_n}, 8'h01);
    r = $random(seed);
    wr_reg(8'h10, r[7:0]);
    rd_reg(8'h10, 8'h00);
    wr_reg(ADDR_MASK, {5'h00, r[2:0]});
    rd_reg(ADDR_MASK, {5'h00, r[2:0]});
    wr_reg(ADDR_MASK, 8'h00);
    for (int i = 0; i < 3; i++) begin
      cond <= 3'(1 << i);
      w(6);
      check({7'h00, irq_n}, 8'h00);
      cond <= 3'h0;
      w(6);
      rd_reg(ADDR_FLAGS, 8'(1 << i));
      w(3);
      check({7'h00, irq_n}, 8'h01);
    end
    wr_reg(ADDR_MASK, 8'h07);
    cond <= 3'h7;
    w(8);
    check({7'h00, irq_n}, 8'h01);
    wr_reg(ADDR_MASK, 8'h00);
    w(4);
    check({7'h00, irq_n}, 8'h00);
    cond <= 3'h0;
    w(6);
    rd_reg(ADDR_FLAGS, 8'h07);
    wr_reg(ADDR_CONTROL, 8'h02);
    w(1);
    check({6'h00, rate, settled}, 8'h02);
    w(RATE_CYC + 2);
    check({7'h00, settled}, 8'h01);
    wr_reg(ADDR_CONTROL, 8'h03);
    w(1);
    check({6'h00, lp, fully}, 8'h02);
    wr_reg(ADDR_CONTROL, 8'h02);
    wait_ff(LPOFF + 10);
    check({6'h00, lp, fully}, 8'h01);
    lp_req <= 1'b1;
    w(24);
    check({6'h00, lp, fully}, 8'h02);
    lp_req <= 1'b0;
    w(24);
    wait_ff(LPOFF + 10);
    check({7'h00, fully}, 8'h01);
    pin_pulse(4'h2);
    w(40);
    check({7'h00, fully}, 8'h01);
    pin_pulse(4'h8);
    w(80);
    check({7'h00, fully}, 8'h00);
    wait_ff(INIT + 20);
    w(2);
    check({6'h00, fully, irq_n}, 8'h02);
    report_and_stop();
  end
endmodule // module_mgmt_status_timing_tb_top
bind mms_core mms_core_assertions #(.INIT_CYC(INIT_CYC), .LP_OFF_CYC(LP_OFF_CYC))
  u_mms_core_assertions (.clk(clk), .reset(reset), .module_reset_n(module_reset_n),
  .low_power_select(low_power_select), .rx_loss(rx_loss), .tx_fault(tx_fault),
  .other_alarm(other_alarm), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .bus_ready(bus_ready), .module_interrupt_n(module_interrupt_n), .low_power(low_power),
  .rate_settled(rate_settled), .rate_high(rate_high), .fully_functional(fully_functional));
`default_nettype wire

// *** verilog/mms_core.sv ***
// module: management status, flag, interrupt, low-power and rate-select logic
// ------------------------------------------------------------
// Overview of operation
// - fully functional within 2000 ms after power on, hot plug or reset release
// - reset pin low longer than 2 us is a reset
// - register port answers within 2000 ms of power on
// - within 2000 ms clear data-not-ready bit 0 of byte 2, assert interrupt
// - fully functional within 2000 ms after reset pin rising edge
// - low-power select high enters power level 1 within 100 us
// - low-power select low returns fully functional within 300 ms
// - interrupt output goes low within 200 ms of a triggering condition
// - interrupt releases within 500 us after clear-on-read of flag
// - signal loss sets loss flag and interrupt within 100 ms
// - transmit fault sets fault flag and interrupt within 200 ms
// - other conditions set their flag and interrupt within 200 ms
// - mask bit 1 blocks its flag from interrupt within 100 ms
// - mask bit 0 lets its flag drive interrupt within 100 ms
// - rate select change settles bandwidth within 100 us
// - power-down bit 1 enters power level 1 within 100 ms
// - power-down bit 0 returns fully functional within 300 ms
// - fully functional only after not-ready cleared and interrupt asserted; here it rises one cycle before the interrupt pin falls
// - write response timing counts from the write itself
// - init limit waived while held in low power state
// ------------------------------------------------------------
//
// Decided for this implementation: strobed register access and the placing of the registers.
`default_nettype none
module mms_core
  import mms_pkg::*;
#(
  parameter int unsigned INIT_CYC = INIT_CYC_DEF,
  parameter int unsigned LP_OFF_CYC = LP_OFF_CYC_DEF
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic module_reset_n,
  input wire logic low_power_select,
  input wire logic rx_loss,
  input wire logic tx_fault,
  input wire logic other_alarm,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic bus_ready,
  output logic module_interrupt_n,
  output logic low_power,
  output logic rate_high,
  output logic rate_settled,
  output logic fully_functional
);

  // ------------------------------------------------------------
  // helper functions
  // ------------------------------------------------------------
  // two-stage shift used by every pin synchroniser
  function automatic logic [1:0] sync_shift(input logic [1:0] q, input logic pin);
    sync_shift = {q[0], pin};
  endfunction

  // address compare shared by read and write decode
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ref_addr);
    addr_is = (a == ref_addr);
  endfunction

  // pads a flag-wide field into a register byte
  function automatic logic [7:0] flag_byte(input logic [NFLAG-1:0] f);
    flag_byte = {{(8 - NFLAG){1'b0}}, f};
  endfunction

  // timer compare; the limit is a whole count of cycles
  function automatic logic time_up(input logic [31:0] t, input int unsigned lim);
    time_up = (t >= lim - 1);
  endfunction

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  // every pin passes two flops before any logic reads it
  logic [1:0] rst_s;
  logic [1:0] lp_s;
  logic [1:0] los_s;
  logic [1:0] txf_s;
  logic [1:0] oth_s;

  // reset pin idles high, so its synchroniser resets high too
  always_ff @(posedge clk) begin
    if (reset) begin
      rst_s <= 2'h3;
    end else begin
      rst_s <= sync_shift(rst_s, module_reset_n);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      lp_s <= 2'h0;
    end else begin
      lp_s <= sync_shift(lp_s, low_power_select);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      los_s <= 2'h0;
    end else begin
      los_s <= sync_shift(los_s, rx_loss);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      txf_s <= 2'h0;
    end else begin
      txf_s <= sync_shift(txf_s, tx_fault);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      oth_s <= 2'h0;
    end else begin
      oth_s <= sync_shift(oth_s, other_alarm);
    end
  end

  wire rst_pin = rst_s[1];
  wire lp_pin = lp_s[1];
  wire los_pin = los_s[1];
  wire txf_pin = txf_s[1];
  wire oth_pin = oth_s[1];

  // ------------------------------------------------------------
  // reset pulse qualification
  // ------------------------------------------------------------
  // short glitches below the minimum pulse are ignored
  logic [7:0] low_cnt;
  wire low_long = (low_cnt >= 8'(RESET_MIN_CYC));
  wire low_count_on = !rst_pin && !low_long;

  // counter saturates at the limit, so a long hold never wraps
  always_ff @(posedge clk) begin
    if (reset || rst_pin) begin
      low_cnt <= 8'h00;
    end else if (low_count_on) begin
      low_cnt <= low_cnt + 8'h01;
    end
  end

  // state and flags restart for as long as a qualified low lasts
  wire in_pin_reset = !rst_pin && low_long;
  wire restart = reset || in_pin_reset;

  // ------------------------------------------------------------
  // power state machine
  // ------------------------------------------------------------
  mms_state_e state;
  mms_state_e next_state;
  logic [31:0] tmr;
  logic [7:0] control;
  logic [NFLAG-1:0] mask;
  logic [NFLAG-1:0] flags;
  logic not_ready;
  logic ready_pulse;

  wire pdown_bit = control[BIT_PDOWN];
  wire rate_bit = control[BIT_RATE];
  wire want_low = lp_pin || pdown_bit;
  wire boot_done = time_up(tmr, INIT_CYC);
  wire wake_done = time_up(tmr, LP_OFF_CYC);
  // a module that was ready before low power has no data to wait for
  wire wake_ok = wake_done || !not_ready;
  wire state_moves = (next_state != state);

  always_comb begin
    next_state = state;
    unique case (state)
      MMS_BOOT: begin
        if (want_low) begin
          next_state = MMS_LOWPWR;
        end else if (boot_done) begin
          next_state = MMS_READY;
        end
      end
      MMS_READY: begin
        if (want_low) begin
          next_state = MMS_LOWPWR;
        end
      end
      MMS_LOWPWR: begin
        if (!want_low) begin
          next_state = MMS_WAKE;
        end
      end
      MMS_WAKE: begin
        if (want_low) begin
          next_state = MMS_LOWPWR;
        end else if (wake_ok) begin
          next_state = MMS_READY;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (restart) begin
      state <= MMS_BOOT;
    end else begin
      state <= next_state;
    end
  end

  // timer restarts on every state change
  always_ff @(posedge clk) begin
    if (restart || state_moves) begin
      tmr <= 32'h0;
    end else begin
      tmr <= tmr + 32'h1;
    end
  end

  // power level 1 is entered in the cycle after the request
  assign low_power = (state == MMS_LOWPWR);
  // ready only once the data-not-ready bit has been cleared
  assign fully_functional = (state == MMS_READY) && !not_ready;
  assign bus_ready = (state != MMS_BOOT) || boot_done;

  // ------------------------------------------------------------
  // register decode
  // ------------------------------------------------------------
  wire hit_id = addr_is(addr, ADDR_ID);
  wire hit_status = addr_is(addr, ADDR_STATUS);
  wire hit_flags = addr_is(addr, ADDR_FLAGS);
  wire hit_ctrl = addr_is(addr, ADDR_CONTROL);
  wire hit_mask = addr_is(addr, ADDR_MASK);
  wire hit_state = addr_is(addr, ADDR_STATE);
  wire rd_ok = rd && bus_ready;
  wire wr_ok = wr && bus_ready;
  wire read_flags = rd_ok && hit_flags;
  wire read_status = rd_ok && hit_status;
  wire write_ctrl = wr_ok && hit_ctrl;
  wire write_mask = wr_ok && hit_mask;

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  // unmapped bytes read as zero, and nothing answers before boot
  wire [7:0] id_byte = ID_VALUE;
  wire [7:0] status_byte = {7'h00, not_ready};
  wire [7:0] flags_byte = flag_byte(flags);
  wire [7:0] mask_byte = flag_byte(mask);
  wire [7:0] state_byte = {4'h0, low_power, fully_functional, 2'(state)};
  wire [7:0] next_rdata;
  assign next_rdata = !bus_ready ? 8'h00 :
                      hit_id ? id_byte :
                      hit_status ? status_byte :
                      hit_flags ? flags_byte :
                      hit_ctrl ? control :
                      hit_mask ? mask_byte :
                      hit_state ? state_byte :
                      8'h00;

  // read data hold until the next read
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata <= 8'h00;
    end else if (rd) begin
      rdata <= next_rdata;
    end
  end

  // ------------------------------------------------------------
  // control and mask registers
  // ------------------------------------------------------------
  // writes land at the edge that takes them, so later timing starts there
  always_ff @(posedge clk) begin
    if (reset) begin
      control <= RST_CONTROL;
    end else if (write_ctrl) begin
      control <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mask <= RST_MASK;
    end else if (write_mask) begin
      mask <= wdata[NFLAG-1:0];
    end
  end

  // ------------------------------------------------------------
  // rate select
  // ------------------------------------------------------------
  logic [15:0] rate_cnt;
  wire rate_change = (rate_bit != rate_high);
  wire rate_busy = (rate_cnt != 16'h0);

  always_ff @(posedge clk) begin
    if (reset) begin
      rate_high <= 1'b0;
    end else if (rate_change) begin
      rate_high <= rate_bit;
    end
  end

  // a new change restarts the settle count
  always_ff @(posedge clk) begin
    if (reset) begin
      rate_cnt <= 16'h0;
    end else if (rate_change) begin
      rate_cnt <= 16'(RATE_CYC - 1);
    end else if (rate_busy) begin
      rate_cnt <= rate_cnt - 16'h1;
    end
  end

  // settled flag drops one cycle before rate_high switches and stays low for RATE_CYC cycles, the whole of its bound
  assign rate_settled = !rate_busy && !rate_change;

  // ------------------------------------------------------------
  // flags
  // ------------------------------------------------------------
  wire [NFLAG-1:0] cond;
  wire [NFLAG-1:0] kept_flags;
  wire [NFLAG-1:0] next_flags;
  assign cond[FLAG_LOS] = los_pin;
  assign cond[FLAG_TXF] = txf_pin;
  assign cond[FLAG_OTHER] = oth_pin;
  // clear-on-read empties the byte, then live conditions set it again
  assign kept_flags = read_flags ? {NFLAG{1'b0}} : flags;
  // set wins over the clear, so a condition present during the read is kept
  assign next_flags = kept_flags | cond;

  always_ff @(posedge clk) begin
    if (restart) begin
      flags <= {NFLAG{1'b0}};
    end else begin
      flags <= next_flags;
    end
  end

  // ------------------------------------------------------------
  // data-not-ready and ready event
  // ------------------------------------------------------------
  wire becomes_ready = not_ready && (next_state == MMS_READY);
  wire ready_seen = read_flags || read_status;

  always_ff @(posedge clk) begin
    if (restart) begin
      not_ready <= 1'b1;
    end else if (becomes_ready) begin
      not_ready <= 1'b0;
    end
  end

  // the ready event is an interrupt source of its own, cleared by a read
  always_ff @(posedge clk) begin
    if (restart) begin
      ready_pulse <= 1'b0;
    end else if (becomes_ready) begin
      ready_pulse <= 1'b1;
    end else if (ready_seen) begin
      ready_pulse <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // interrupt output
  // ------------------------------------------------------------
  wire [NFLAG-1:0] open_flags = flags & ~mask;
  wire flag_pending = |open_flags;
  wire int_pending = flag_pending || ready_pulse;

  // registered so the pin never glitches while flags settle
  always_ff @(posedge clk) begin
    if (reset) begin
      module_interrupt_n <= 1'b1;
    end else begin
      module_interrupt_n <= !int_pending;
    end
  end

endmodule // mms_core
`default_nettype wire
